//--- rtl/boc_pkg.sv
/*
 Package for the boost converter control block: register offsets, field
 positions, reset values, timing constants and the carrier structs.
 Assumes a 100 MHz system clock and 8-bit register data.
*/
package boc_pkg;

    // =====================================================================
    // clock and timing
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned INT_OSC_HZ = 2_400_000;
    localparam int unsigned INT_OSC_CYC = CLK_HZ / INT_OSC_HZ;
    localparam int unsigned MIN_PULSE_WIDTH_20_NS = 20;
    localparam int unsigned MIN_PULSE_WIDTH_40_NS = 40;
    localparam int unsigned MIN_PULSE_WIDTH_80_NS = 80;
    // least times round up to whole cycles
    localparam logic [7:0] MIN_PULSE_WIDTH_20_CYC = 8'((MIN_PULSE_WIDTH_20_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] MIN_PULSE_WIDTH_40_CYC = 8'((MIN_PULSE_WIDTH_40_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] MIN_PULSE_WIDTH_80_CYC = 8'((MIN_PULSE_WIDTH_80_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [5:0] DIV_CNT_MAX = 6'(INT_OSC_CYC - 1);

    // =====================================================================
    // register map
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CFG = 8'h01;
    localparam logic [7:0] ADDR_STATUS = 8'h02;
    localparam logic [7:0] CTRL_RST = 8'h21;
    localparam logic [7:0] CTRL_WMASK = 8'hEF;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [7:0] CFG_WMASK = 8'h7F;

    // field encodings
    localparam logic [1:0] DIV_BY_1 = 2'h0;
    localparam logic [1:0] DIV_BY_2 = 2'h1;
    localparam logic [1:0] DIV_BY_4 = 2'h2;
    localparam logic [1:0] DIV_BY_8 = 2'h3;
    localparam logic [1:0] MIN_PULSE_WIDTH_NONE = 2'h0;
    localparam logic [1:0] MIN_PULSE_WIDTH_20 = 2'h1;
    localparam logic [1:0] MIN_PULSE_WIDTH_40 = 2'h2;
    localparam logic [1:0] MIN_PULSE_WIDTH_80 = 2'h3;

    // =====================================================================
    // carriers, bit 7 down to bit 0
    typedef struct packed {
        logic reserved;
        logic [1:0] converter_clock_divider;
        logic adc_clock_invert;
        logic system_clock_invert;
        logic peak_current_limit;
        logic sleep_output_float;
        logic converter_clock_source_select;
    } boc_cfg_t;

    typedef struct packed {
        logic [1:0] min_pulse_width;
        logic switch_size_select;
        logic reserved;
        logic adc_sync;
        logic [2:0] voltage_select;
    } boc_ctrl_t;

    typedef enum logic [1:0] {
        PWM_WAIT = 2'h0,
        PWM_ON = 2'h1,
        PWM_SKIP = 2'h3
    } boc_pwm_t;

endpackage : boc_pkg

//--- rtl/boc_clkgen.sv
/*
 Converter clock generator: produces a one-cycle tick per converter clock
 period from the internal oscillator divider or from the divided system clock.
 Assumes settings come from the register file in the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module boc_clkgen (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // settings and run
    input wire boc_pkg::boc_cfg_t cfg,
    input wire logic run,
    // converter clock tick
    output logic tick
);

    // =====================================================================
    // divider
    boc_pkg::boc_cfg_t act_q;
    logic [5:0] cnt_q;
    logic tick_raw_q;
    logic tick_dly_q;
    logic [5:0] sys_max;
    logic [5:0] cnt_max;
    logic wrap;
    logic inv_now;
    logic inv_hold_q;

    // divider field only counts on the system clock path
    assign sys_max = (act_q.converter_clock_divider == boc_pkg::DIV_BY_1) ? 6'h00 :
                     (act_q.converter_clock_divider == boc_pkg::DIV_BY_2) ? 6'h01 :
                     (act_q.converter_clock_divider == boc_pkg::DIV_BY_4) ? 6'h03 : 6'h07; // RULE_13
    assign cnt_max = act_q.converter_clock_source_select ? sys_max : boc_pkg::DIV_CNT_MAX; // RULE_06 RULE_07 RULE_08 RULE_14
    assign wrap = (cnt_q >= cnt_max);

    always_ff @(posedge clk) begin
        if (!nrst || !run) begin
            cnt_q <= 6'h00;
            tick_raw_q <= 1'b0;
        end else begin
            cnt_q <= wrap ? 6'h00 : cnt_q + 6'h01;
            tick_raw_q <= wrap;
        end
    end

    // new settings take effect only at a period boundary or while run is low, so no runt period
    always_ff @(posedge clk) begin
        if (!nrst) begin
            act_q <= boc_pkg::CFG_RST;
        end else if (wrap || !run) begin
            act_q <= cfg; // RULE_16
        end
    end

    // inversion shifts the sampled edge by one system cycle
    always_ff @(posedge clk) begin
        if (!nrst) begin
            tick_dly_q <= 1'b0;
            inv_hold_q <= 1'b0;
        end else begin
            tick_dly_q <= tick_raw_q;
            inv_hold_q <= inv_now;
        end
    end

    assign inv_now = act_q.converter_clock_source_select && act_q.system_clock_invert; // RULE_09
    // leaving inversion stays on the delayed path one more cycle, else that period comes up one short
    assign tick = (inv_now || inv_hold_q) ? tick_dly_q : tick_raw_q; // RULE_09 RULE_16

    a_int_period: assert property (@(posedge clk) disable iff (!nrst) // RULE_07
        (run && !act_q.converter_clock_source_select && wrap)
        |=> (!wrap || !run || act_q.converter_clock_source_select) [*8])
        else $error("internal oscillator period too short");

endmodule : boc_clkgen

`default_nettype wire

//--- rtl/boc_top.sv
/*
 Boost converter control: strap latch at reset, enable by power mode,
 clock selection, pulse skipping, sleep rail handling and register port.
 Assumes a synchronous register master and a regulator that supplies the
 wanted switch-on width, in system cycles, for each converter period.
*/
`timescale 1ns/1ps
`default_nettype none

// Contract
// RULE_01: at reset the strap is sampled and one-cell or two-cell mode latched.
// RULE_02: two-cell mode keeps the converter disabled always.
// RULE_03: one-cell mode disables the converter in sleep, enables it otherwise.
// RULE_04: latched mode changes only at reset; later strap changes are ignored.
// RULE_05: a pulse narrower than the minimum width is skipped whole.
// RULE_06: config bit 0 picks internal oscillator or system clock.
// RULE_07: internal oscillator near 2.4 MHz clocks the converter when selected.
// RULE_08: config bits 6:5 divide the system clock for the converter.
// RULE_09: invert bit set inverts system clock before the divider.
// RULE_10: sleep disables converter and ties output rail to battery by default.
// RULE_11: sleep float bit set leaves the rail floating in sleep.
// RULE_12: peak current limit defaults low after reset.
// RULE_13: divider codes 00,01,10,11 give divide by 1,2,4,8.
// RULE_14: divider field ignored on the internal oscillator.
// RULE_15: minimum width codes: none, 20 ns, 40 ns, 80 ns.
// RULE_16: clock setting changes cause no glitch or runt converter clock.
module boc_top (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // power mode and strap
    input wire logic sleep_mode,
    input wire logic converter_strap_pin,
    // regulation demand, in system cycles per converter period
    input wire logic [7:0] pulse_width_req,
    // converter controls
    output logic converter_enable,
    output logic switch_drive,
    output logic converter_clk_tick,
    output logic pulse_skipped,
    output logic rail_to_battery,
    output logic one_cell_mode,
    output logic peak_current_limit,
    output logic switch_size_select,
    output logic [2:0] voltage_select
);

    // =====================================================================
    // register file
    boc_pkg::boc_ctrl_t ctrl_q;
    boc_pkg::boc_cfg_t cfg_q;
    logic [7:0] rdata_q;
    logic [7:0] rd_mux;
    logic [7:0] status;
    logic hit_ctrl;
    logic hit_cfg;
    logic hit_status;
    logic wr_ctrl;
    logic wr_cfg;

    assign hit_ctrl = (reg_addr == boc_pkg::ADDR_CTRL);
    assign hit_cfg = (reg_addr == boc_pkg::ADDR_CFG);
    assign hit_status = (reg_addr == boc_pkg::ADDR_STATUS);
    assign wr_ctrl = reg_write && hit_ctrl;
    assign wr_cfg = reg_write && hit_cfg;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ctrl_q <= boc_pkg::CTRL_RST;
            cfg_q <= boc_pkg::CFG_RST; // RULE_12
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= reg_wdata & boc_pkg::CTRL_WMASK;
            end
            if (wr_cfg) begin
                cfg_q <= reg_wdata & boc_pkg::CFG_WMASK;
            end
        end
    end

    // unmapped addresses read zero
    assign rd_mux = hit_ctrl ? ctrl_q :
                    hit_cfg ? cfg_q :
                    hit_status ? status : 8'h00;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= reg_read ? rd_mux : 8'h00;
        end
    end

    // =====================================================================
    // strap latch and enable
    logic por_done_q;
    logic one_cell_q;
    logic enable_q;
    logic rail_tie_q;
    logic enable_d;
    logic rail_tie_d;

    // caught by a clocked process after release, never by the reset itself
    always_ff @(posedge clk) begin
        if (!nrst) begin
            por_done_q <= 1'b0;
            one_cell_q <= 1'b0;
        end else if (!por_done_q) begin
            por_done_q <= 1'b1;
            one_cell_q <= converter_strap_pin; // RULE_01 RULE_04
        end
    end

    assign enable_d = por_done_q && one_cell_q && !sleep_mode; // RULE_02 RULE_03 RULE_10
    assign rail_tie_d = sleep_mode && !cfg_q.sleep_output_float; // RULE_10 RULE_11

    always_ff @(posedge clk) begin
        if (!nrst) begin
            enable_q <= 1'b0;
            rail_tie_q <= 1'b0;
        end else begin
            enable_q <= enable_d;
            rail_tie_q <= rail_tie_d;
        end
    end

    // =====================================================================
    // converter clock
    logic tick;
    logic tick_q;

    boc_clkgen u_clkgen (
        .clk(clk),
        .nrst(nrst),
        .cfg(cfg_q),
        .run(enable_q),
        .tick(tick)
    );

    always_ff @(posedge clk) begin
        if (!nrst) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= tick;
        end
    end

    // =====================================================================
    // pulse width with skipping
    boc_pkg::boc_pwm_t pwm_q;
    boc_pkg::boc_pwm_t pwm_d;
    logic [7:0] min_cyc;
    logic [7:0] on_cnt_q;
    logic [7:0] on_cnt_d;
    logic too_narrow;
    logic skip_q;

    assign min_cyc = (ctrl_q.min_pulse_width == boc_pkg::MIN_PULSE_WIDTH_20) ? boc_pkg::MIN_PULSE_WIDTH_20_CYC :
                     (ctrl_q.min_pulse_width == boc_pkg::MIN_PULSE_WIDTH_40) ? boc_pkg::MIN_PULSE_WIDTH_40_CYC :
                     (ctrl_q.min_pulse_width == boc_pkg::MIN_PULSE_WIDTH_80) ? boc_pkg::MIN_PULSE_WIDTH_80_CYC : 8'h00; // RULE_15
    // a zero request is no pulse at all, not a skip
    assign too_narrow = (pulse_width_req != 8'h00) && (pulse_width_req < min_cyc); // RULE_05

    always_comb begin
        pwm_d = pwm_q;
        on_cnt_d = on_cnt_q;
        case (pwm_q)
            boc_pkg::PWM_WAIT: begin
                if (tick && too_narrow) begin
                    pwm_d = boc_pkg::PWM_SKIP; // RULE_05
                end else if (tick && pulse_width_req != 8'h00) begin
                    pwm_d = boc_pkg::PWM_ON;
                    on_cnt_d = pulse_width_req - 8'h01;
                end
            end
            boc_pkg::PWM_ON: begin
                if (on_cnt_q == 8'h00) begin
                    pwm_d = boc_pkg::PWM_WAIT;
                end else begin
                    on_cnt_d = on_cnt_q - 8'h01;
                end
            end
            boc_pkg::PWM_SKIP: begin
                pwm_d = boc_pkg::PWM_WAIT;
            end
            default: begin
                pwm_d = boc_pkg::PWM_WAIT;
            end
        endcase
        if (!enable_q) begin
            pwm_d = boc_pkg::PWM_WAIT;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            pwm_q <= boc_pkg::PWM_WAIT;
            on_cnt_q <= 8'h00;
            skip_q <= 1'b0;
        end else begin
            pwm_q <= pwm_d;
            on_cnt_q <= on_cnt_d;
            skip_q <= (pwm_d == boc_pkg::PWM_SKIP);
        end
    end

    // =====================================================================
    // outputs
    logic drive_q;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            drive_q <= 1'b0;
        end else begin
            drive_q <= (pwm_d == boc_pkg::PWM_ON);
        end
    end

    assign status = {4'h0, skip_q, rail_tie_q, enable_q, one_cell_q};
    assign reg_rdata = rdata_q;
    assign converter_enable = enable_q;
    assign switch_drive = drive_q;
    assign converter_clk_tick = tick_q;
    assign pulse_skipped = skip_q;
    assign rail_to_battery = rail_tie_q;
    assign one_cell_mode = one_cell_q;
    assign peak_current_limit = cfg_q.peak_current_limit;
    assign switch_size_select = ctrl_q.switch_size_select;
    assign voltage_select = ctrl_q.voltage_select;

    // =====================================================================
    // checks
    a_strap_held: assert property (@(posedge clk) disable iff (!nrst) // RULE_04
        $past(por_done_q) |-> $stable(one_cell_q))
        else $error("latched cell mode changed after reset");

    a_strap_caught: assert property (@(posedge clk) disable iff (!nrst) // RULE_01
        $rose(por_done_q) |-> one_cell_q == $past(converter_strap_pin))
        else $error("strap not latched at release");

    a_two_cell_off: assert property (@(posedge clk) disable iff (!nrst) // RULE_02
        !one_cell_q |=> !converter_enable)
        else $error("converter enabled in two-cell mode");

    a_sleep_off: assert property (@(posedge clk) disable iff (!nrst) // RULE_03
        (sleep_mode || !por_done_q) |=> !converter_enable)
        else $error("converter enabled in sleep");

    a_awake_on: assert property (@(posedge clk) disable iff (!nrst) // RULE_03
        (por_done_q && one_cell_q && !sleep_mode) |=> converter_enable)
        else $error("converter not enabled while awake");

    a_rail_tie: assert property (@(posedge clk) disable iff (!nrst) // RULE_10
        (sleep_mode && !cfg_q.sleep_output_float) |=> rail_to_battery)
        else $error("rail not tied to battery in sleep");

    a_rail_float: assert property (@(posedge clk) disable iff (!nrst) // RULE_11
        (cfg_q.sleep_output_float || !sleep_mode) |=> !rail_to_battery)
        else $error("rail tied while floating");

    a_skip_nodrive: assert property (@(posedge clk) disable iff (!nrst) // RULE_05
        (enable_q && tick && too_narrow && pwm_q == boc_pkg::PWM_WAIT) |=> (pulse_skipped && !switch_drive))
        else $error("narrow pulse not skipped");

    a_pulse_len: assert property (@(posedge clk) disable iff (!nrst) // RULE_15
        (enable_q && tick && pwm_q == boc_pkg::PWM_WAIT && !too_narrow && pulse_width_req == boc_pkg::MIN_PULSE_WIDTH_20_CYC
         && ctrl_q.min_pulse_width == boc_pkg::MIN_PULSE_WIDTH_20 && !sleep_mode) |=> switch_drive [*2])
        else $error("minimum width pulse cut short");

    a_limit_reset: assert property (@(posedge clk) // RULE_12
        !nrst |=> !peak_current_limit)
        else $error("current limit not low after reset");

    a_limit_held: assert property (@(posedge clk) disable iff (!nrst) // RULE_12
        !wr_cfg |=> $stable(peak_current_limit))
        else $error("current limit moved without a write");

    a_strap_ignored: assert property (@(posedge clk) disable iff (!nrst) // RULE_04
        (por_done_q && $changed(converter_strap_pin)) |=> $stable(one_cell_mode))
        else $error("strap change after reset reached the cell mode");

    a_two_cell_nodrive: assert property (@(posedge clk) disable iff (!nrst) // RULE_02
        (por_done_q && !one_cell_q) |-> ##2 !switch_drive)
        else $error("switch driven in two-cell mode");

    a_sleep_nodrive: assert property (@(posedge clk) disable iff (!nrst) // RULE_10
        sleep_mode |-> ##2 !switch_drive)
        else $error("switch driven in sleep");

    a_skip_quiet: assert property (@(posedge clk) disable iff (!nrst) // RULE_05
        pulse_skipped |-> !switch_drive)
        else $error("switch driven in a skipped period");

    a_nomin_pulse: assert property (@(posedge clk) disable iff (!nrst) // RULE_15
        (enable_q && tick && pwm_q == boc_pkg::PWM_WAIT && pulse_width_req != 8'h00
         && ctrl_q.min_pulse_width == boc_pkg::MIN_PULSE_WIDTH_NONE) |=> switch_drive)
        else $error("pulse skipped with no minimum set");

    a_skip_eighty: assert property (@(posedge clk) disable iff (!nrst) // RULE_15
        (enable_q && tick && pwm_q == boc_pkg::PWM_WAIT && pulse_width_req != 8'h00
         && pulse_width_req < boc_pkg::MIN_PULSE_WIDTH_80_CYC && ctrl_q.min_pulse_width == boc_pkg::MIN_PULSE_WIDTH_80)
        |=> pulse_skipped)
        else $error("pulse under the 80 ns minimum not skipped");

endmodule : boc_top

`default_nettype wire

//--- bench/boost_converter_control_tb.sv
/*
 Self-checking bench for the boost converter control block (boc_top).
 Assumes boc_pkg and boc_top are compiled first; the bench drives all ports.
*/
`timescale 1ns/1ps
`default_nettype none

module boost_converter_control_tb;
    // ====================================================================
    // ports and counters
    logic clk, nrst, reg_write, reg_read, sleep_mode, converter_strap_pin;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, pulse_width_req, d, s, hi, sk, r;
    logic converter_enable, switch_drive, converter_clk_tick, pulse_skipped;
    logic rail_to_battery, one_cell_mode, peak_current_limit, switch_size_select;
    logic [2:0] voltage_select;
    int num_errors = 0;
    int total_checks = 0;
    int n, prev;
    logic [7:0] cfgs [6] = '{8'h01, 8'h21, 8'h41, 8'h61, 8'h69, 8'h60};
    logic [7:0] mins [4] = '{8'h00, 8'h02, 8'h04, 8'h08};
    logic [7:0] reqs [4];

    boc_top dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .sleep_mode(sleep_mode), .converter_strap_pin(converter_strap_pin),
        .pulse_width_req(pulse_width_req), .converter_enable(converter_enable),
        .switch_drive(switch_drive), .converter_clk_tick(converter_clk_tick),
        .pulse_skipped(pulse_skipped), .rail_to_battery(rail_to_battery),
        .one_cell_mode(one_cell_mode), .peak_current_limit(peak_current_limit),
        .switch_size_select(switch_size_select), .voltage_select(voltage_select));

    // ====================================================================
    // helpers
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr

    // converter period in system cycles for a config byte
    function automatic logic [7:0] exp_per(input logic [7:0] c);
        if (c[0]) begin
            return 8'h01 << c[6:5];
        end
        return 8'(boc_pkg::INT_OSC_CYC);
    endfunction : exp_per

    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        v = reg_rdata;
    endtask : rd

    // bounded wait for the next converter tick, returns cycles waited
    task automatic wait_tick(output int cnt);
        cnt = 0;
        do begin
            @(posedge clk);
            #1;
            cnt++;
        end while (converter_clk_tick !== 1'b1 && cnt < 400);
        if (cnt >= 400) begin
            chk(8'h00, 8'h01);
            complete_run();
        end
    endtask : wait_tick

    // counts drive and skip cycles over one period from a tick
    task automatic pulse_win(input logic [7:0] per, output logic [7:0] h, output logic [7:0] k);
        int c;
        wait_tick(c);
        wait_tick(c);
        h = 8'h00;
        k = 8'h00;
        for (int i = 0; i < per; i++) begin
            if (i > 0) begin
                @(posedge clk);
                #1;
            end
            h = h + 8'(switch_drive);
            k = k + 8'(pulse_skipped);
        end
    endtask : pulse_win

    task automatic do_reset;
        @(posedge clk);
        nrst <= 1'b0;
        repeat (10) @(posedge clk);
        #1;
        chk({switch_size_select, voltage_select, converter_enable}, 8'h12);
        @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
    endtask : do_reset

    // ====================================================================
    // clock, watchdog, main sequence
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        repeat (100000) @(posedge clk);
        chk(8'h00, 8'h01);
        complete_run();
    end

    initial begin
        nrst = 1'b0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        sleep_mode = 1'b0;
        converter_strap_pin = 1'b1;
        pulse_width_req = 8'h00;
        s = 8'h0E;
        do_reset();
        rd(boc_pkg::ADDR_CTRL, d);
        chk(d, boc_pkg::CTRL_RST);
        rd(boc_pkg::ADDR_CFG, d);
        chk(d, boc_pkg::CFG_RST);
        chk({7'h00, peak_current_limit}, 8'h00);
        rd(boc_pkg::ADDR_STATUS, d);
        chk(d, 8'h03);
        wr(boc_pkg::ADDR_STATUS, 8'hFF);
        rd(8'h07, d);
        chk(d, 8'h00);
        rd(boc_pkg::ADDR_STATUS, d);
        chk(d, 8'h03);
        for (int i = 0; i < 4; i++) begin
            s = lfsr(s);
            wr(boc_pkg::ADDR_CTRL, s);
            rd(boc_pkg::ADDR_CTRL, d);
            chk(d, s & 8'hEF);
            chk({4'h0, switch_size_select, voltage_select}, {4'h0, s[5], s[2:0]});
            s = lfsr(s);
            wr(boc_pkg::ADDR_CFG, s);
            rd(boc_pkg::ADDR_CFG, d);
            chk(d, s & 8'h7F);
            chk({7'h00, peak_current_limit}, {7'h00, s[2]});
        end
        wr(boc_pkg::ADDR_CFG, 8'h00);
        $display("done: registers");
        converter_strap_pin <= 1'b0;
        repeat (5) @(posedge clk);
        #1;
        chk({6'h00, one_cell_mode, converter_enable}, 8'h03);
        @(posedge clk);
        sleep_mode <= 1'b1;
        @(posedge clk);
        #1;
        chk({6'h00, converter_enable, rail_to_battery}, 8'h01);
        wr(boc_pkg::ADDR_CFG, 8'h02);
        @(posedge clk);
        #1;
        chk({7'h00, rail_to_battery}, 8'h00);
        wr(boc_pkg::ADDR_CFG, 8'h00);
        sleep_mode <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk({6'h00, converter_enable, rail_to_battery}, 8'h02);
        $display("done: strap and sleep");
        prev = 1;
        for (int i = 0; i < 6; i++) begin
            wr(boc_pkg::ADDR_CFG, cfgs[i]);
            // first wait ends a partial period: it only aligns to a tick
            wait_tick(n);
            for (int j = 0; j < 3; j++) begin
                wait_tick(n);
                chk({7'h00, n >= prev}, 8'h01);
            end
            chk(8'(n), exp_per(cfgs[i]));
            prev = exp_per(cfgs[i]);
        end
        $display("done: clocking");
        wr(boc_pkg::ADDR_CFG, 8'h61);
        for (int c = 0; c < 4; c++) begin
            wr(boc_pkg::ADDR_CTRL, {2'(c), 6'h21});
            s = lfsr(s);
            reqs = '{8'h01, mins[c] - 8'h01, mins[c], 8'h01 + (s % 8'h06)};
            foreach (reqs[k]) begin
                r = reqs[k];
                if (r >= 8'h01 && r <= 8'h06) begin
                    @(posedge clk);
                    pulse_width_req <= r;
                    pulse_win(8'h08, hi, sk);
                    chk(hi, (r < mins[c]) ? 8'h00 : r);
                    chk(sk, (r < mins[c]) ? 8'h01 : 8'h00);
                end
            end
        end
        @(posedge clk);
        pulse_width_req <= 8'h00;
        $display("done: pulse skipping");
        do_reset();
        @(posedge clk);
        converter_strap_pin <= 1'b1;
        repeat (20) @(posedge clk);
        #1;
        chk({6'h00, one_cell_mode, converter_enable}, 8'h00);
        @(posedge clk);
        sleep_mode <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk({6'h00, converter_enable, rail_to_battery}, 8'h01);
        $display("done: two-cell");
        complete_run();
    end
endmodule : boost_converter_control_tb

`default_nettype wire
